// ===== hdl/dfc_top.sv
// Format command handler with AXI4-Lite command block and zero-fill write path
`timescale 1ns/1ps
module dfc_top (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             MEDIA_ZERO_VALID,
  output logic [27:0]      MEDIA_ZERO_LBA,
  input  wire logic        MEDIA_ZERO_READY,
  output logic             IRQ
);
  typedef enum logic [2:0] {S_IDLE, S_DEC, S_MERGE, S_FILL, S_FIN} dfc_state_t;

  dfc_state_t  state;
  logic        busy;
  logic [7:0]  cmd;
  logic [7:0]  err;
  logic [7:0]  sect;
  logic [7:0]  cyl_lo;
  logic [7:0]  cyl_hi;
  logic [7:0]  drv_head;
  logic [7:0]  feat;
  logic        armed;
  logic        lba_mode;
  logic        fin;
  logic [27:0] cur;
  logic [27:0] last;
  logic [27:0] nat_max;
  logic [15:0] reassign;
  logic [15:0] defect;
  logic [1:0]  int_stat;
  logic [1:0]  int_mask;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_held;
  logic        w_held;
  logic        wr_do;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_val;
  logic [7:0]  status_val;
  logic [27:0] tgt_lba;
  logic [27:0] trk_start;
  logic [27:0] trk_end;
  logic [27:0] trk_last;

  // Bus write fires once both halves are held and no response is pending
  assign wr_do = aw_held && w_held && !S_AXI_BVALID;

  always_comb begin
    status_val = 8'h00;
    status_val[dfc_pkg::ST_BSY] = busy;
    status_val[dfc_pkg::ST_RDY] = !busy;
    status_val[dfc_pkg::ST_DSC] = !busy;
    status_val[dfc_pkg::ST_DRQ] = 1'b0;
    status_val[dfc_pkg::ST_ERR] = !busy && (|err);
  end

  // Target address, either mode
  always_comb begin
    if (drv_head[dfc_pkg::DH_LBA]) begin
      tgt_lba = {drv_head[3:0], cyl_hi, cyl_lo, sect};
    end else begin
      tgt_lba = 28'(({cyl_hi, cyl_lo} * dfc_pkg::HEADS + 28'(drv_head[3:0])) * dfc_pkg::SECT_PER_TRK);
    end
    trk_start = tgt_lba - 28'(tgt_lba % dfc_pkg::SECT_PER_TRK);
    trk_end = trk_start + dfc_pkg::SECT_PER_TRK - 28'h0000001;
    trk_last = (trk_end > nat_max) ? nat_max : trk_end;
  end

  // Command engine and command block registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= S_IDLE;
      busy <= 1'b0;
      cmd <= 8'h00;
      err <= 8'h00;
      sect <= 8'h00;
      cyl_lo <= 8'h00;
      cyl_hi <= 8'h00;
      drv_head <= dfc_pkg::DH_RST;
      feat <= 8'h00;
      armed <= 1'b0;
      lba_mode <= 1'b0;
      fin <= 1'b0;
      cur <= 28'h0000000;
      last <= 28'h0000000;
      nat_max <= dfc_pkg::NAT_MAX_RST;
      reassign <= 16'h0000;
      defect <= 16'h0000;
      MEDIA_ZERO_VALID <= 1'b0;
    end else begin
      fin <= 1'b0;
      case (state)
        S_IDLE: begin
          // Writes to these registers while busy are dropped, as a disk ignores them under BSY
          if (wr_do && w_strb[0]) begin
            case (aw_addr)
              dfc_pkg::OFF_SECT:     sect <= w_data[7:0];
              dfc_pkg::OFF_CYL_LO:   cyl_lo <= w_data[7:0];
              dfc_pkg::OFF_CYL_HI:   cyl_hi <= w_data[7:0];
              dfc_pkg::OFF_DRV_HEAD: drv_head <= w_data[7:0];
              dfc_pkg::OFF_FEATURE:  feat <= w_data[7:0];
              dfc_pkg::OFF_COMMAND: begin
                cmd <= w_data[7:0];
                busy <= 1'b1;
                err <= 8'h00;
                lba_mode <= drv_head[dfc_pkg::DH_LBA];
                state <= S_DEC;
              end
              dfc_pkg::OFF_NAT_MAX: begin
                if (w_strb == 4'hF) begin
                  nat_max <= w_data[27:0];
                end
              end
              dfc_pkg::OFF_REASSIGN: begin
                if (w_strb[1]) begin
                  reassign <= w_data[15:0];
                end
              end
              default: ;
            endcase
          end
        end
        S_DEC: begin
          armed <= 1'b0;
          case (cmd)
            dfc_pkg::CMD_FMT_TRACK: begin
              if (tgt_lba > nat_max) begin
                err[dfc_pkg::ER_ABT] <= 1'b1;
                state <= S_FIN;
              end else begin
                cur <= trk_start;
                last <= trk_last;
                MEDIA_ZERO_VALID <= 1'b1;
                state <= S_FILL;
              end
            end
            dfc_pkg::CMD_FMT_UNIT: begin
              // Reserved feature values are refused too
              if (!armed || feat != dfc_pkg::FEAT_FMT_UNIT) begin
                err[dfc_pkg::ER_ABT] <= 1'b1;
                state <= S_FIN;
              end else begin
                state <= S_MERGE;
              end
            end
            dfc_pkg::CMD_ERASE_PREP: begin
              armed <= 1'b1;
              state <= S_FIN;
            end
            default: begin
              err[dfc_pkg::ER_ABT] <= 1'b1;
              state <= S_FIN;
            end
          endcase
        end
        S_MERGE: begin
          defect <= defect + reassign;
          reassign <= 16'h0000;
          cur <= 28'h0000000;
          last <= nat_max;
          MEDIA_ZERO_VALID <= 1'b1;
          state <= S_FILL;
        end
        S_FILL: begin
          // Zeros only, ascending order, no read-back; any table is ignored
          if (MEDIA_ZERO_READY && MEDIA_ZERO_VALID) begin
            if (cur == last) begin
              MEDIA_ZERO_VALID <= 1'b0;
              state <= S_FIN;
            end else begin
              cur <= cur + 28'h0000001;
            end
          end
        end
        S_FIN: begin
          busy <= 1'b0;
          fin <= 1'b1;
          state <= S_IDLE;
          if (lba_mode && cmd == dfc_pkg::CMD_FMT_TRACK && err == 8'h00) begin
            {drv_head[3:0], cyl_hi, cyl_lo, sect} <= cur;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign MEDIA_ZERO_LBA = cur;

  // Interrupt status, set wins over write-one-to-clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      int_stat <= 2'h0;
      int_mask <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~((wr_do && aw_addr == dfc_pkg::OFF_INT_STAT && w_strb[0]) ? w_data[1:0] : 2'h0))
                  | {fin && (|err), fin};
      if (wr_do && aw_addr == dfc_pkg::OFF_INT_MASK && w_strb[0]) begin
        int_mask <= w_data[1:0];
      end
      IRQ <= |(int_stat & int_mask);
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    case (aw_addr)
      dfc_pkg::OFF_SECT, dfc_pkg::OFF_CYL_LO, dfc_pkg::OFF_CYL_HI, dfc_pkg::OFF_DRV_HEAD,
      dfc_pkg::OFF_FEATURE, dfc_pkg::OFF_COMMAND, dfc_pkg::OFF_INT_STAT, dfc_pkg::OFF_INT_MASK,
      dfc_pkg::OFF_NAT_MAX, dfc_pkg::OFF_REASSIGN: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case (S_AXI_ARADDR)
      dfc_pkg::OFF_SECT:     rd_val = {24'h000000, sect};
      dfc_pkg::OFF_CYL_LO:   rd_val = {24'h000000, cyl_lo};
      dfc_pkg::OFF_CYL_HI:   rd_val = {24'h000000, cyl_hi};
      dfc_pkg::OFF_DRV_HEAD: rd_val = {24'h000000, drv_head};
      dfc_pkg::OFF_FEATURE:  rd_val = {24'h000000, feat};
      dfc_pkg::OFF_COMMAND:  rd_val = {24'h000000, status_val};
      dfc_pkg::OFF_ERROR:    rd_val = {24'h000000, err};
      dfc_pkg::OFF_STATUS:   rd_val = {24'h000000, status_val};
      dfc_pkg::OFF_INT_STAT: rd_val = {30'h00000000, int_stat};
      dfc_pkg::OFF_INT_MASK: rd_val = {30'h00000000, int_mask};
      dfc_pkg::OFF_NAT_MAX:  rd_val = {4'h0, nat_max};
      dfc_pkg::OFF_REASSIGN: rd_val = {16'h0000, reassign};
      dfc_pkg::OFF_DEFECT:   rd_val = {16'h0000, defect};
      default:      rd_ok = 1'b0;
    endcase
  end

  // AXI4-Lite write channels, address and data taken in either order
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= dfc_pkg::RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_do) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? dfc_pkg::RESP_OKAY : dfc_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel, data one cycle after the address is taken
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= dfc_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? dfc_pkg::RESP_OKAY : dfc_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID) begin
        if (S_AXI_RREADY) begin
          S_AXI_RVALID <= 1'b0;
          S_AXI_ARREADY <= 1'b1;
        end
      end else begin
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_trk_go;
    state == S_DEC && cmd == dfc_pkg::CMD_FMT_TRACK;
  endsequence
  sequence s_unit_go;
    state == S_DEC && cmd == dfc_pkg::CMD_FMT_UNIT;
  endsequence

  property p_no_drq;
    busy && cmd == dfc_pkg::CMD_FMT_UNIT |-> !status_val[dfc_pkg::ST_DRQ];
  endproperty
  a_no_drq: assert property (p_no_drq) else $error("data request raised");

  property p_unit_abort;
    s_unit_go ##0 !armed |=> state == S_FIN ##1 fin && err[dfc_pkg::ER_ABT] && !MEDIA_ZERO_VALID;
  endproperty
  a_unit_abort: assert property (p_unit_abort) else $error("unarmed unit format not aborted");

  property p_trk_range;
    s_trk_go ##0 tgt_lba > nat_max |=> state == S_FIN && err[dfc_pkg::ER_ABT]
      ##1 fin && status_val[dfc_pkg::ST_ERR];
  endproperty
  a_trk_range: assert property (p_trk_range) else $error("out of range not aborted");

  property p_trk_align;
    s_trk_go ##0 tgt_lba <= nat_max |=> MEDIA_ZERO_VALID && 28'(cur % dfc_pkg::SECT_PER_TRK) == 28'h0000000
      && cur <= $past(tgt_lba) && last - cur < dfc_pkg::SECT_PER_TRK;
  endproperty
  a_trk_align: assert property (p_trk_align) else $error("track start wrong");

  property p_lba_map;
    state == S_DEC && drv_head[dfc_pkg::DH_LBA] |-> tgt_lba == {drv_head[3:0], cyl_hi, cyl_lo, sect};
  endproperty
  a_lba_map: assert property (p_lba_map) else $error("address assembly wrong");

  property p_merge;
    state == S_MERGE |=> reassign == 16'h0000 && defect == 16'($past(defect) + $past(reassign));
  endproperty
  a_merge: assert property (p_merge) else $error("defect merge wrong");

  property p_unit_span;
    s_unit_go ##0 armed && feat == dfc_pkg::FEAT_FMT_UNIT |=> state == S_MERGE ##1
      MEDIA_ZERO_VALID && MEDIA_ZERO_LBA == 28'h0000000 && last == nat_max;
  endproperty
  a_unit_span: assert property (p_unit_span) else $error("unit span wrong");

  property p_fill_step;
    MEDIA_ZERO_VALID && MEDIA_ZERO_READY && cur != last |=> MEDIA_ZERO_LBA == $past(cur) + 28'h0000001;
  endproperty
  a_fill_step: assert property (p_fill_step) else $error("fill not sequential");

  property p_fin_status;
    fin |-> !busy && status_val[dfc_pkg::ST_RDY] && status_val[dfc_pkg::ST_ERR] == (|err);
  endproperty
  a_fin_status: assert property (p_fin_status) else $error("completion status wrong");

  property p_report;
    fin && lba_mode && cmd == dfc_pkg::CMD_FMT_TRACK && err == 8'h00 |->
      {drv_head[3:0], cyl_hi, cyl_lo, sect} == last;
  endproperty
  a_report: assert property (p_report) else $error("address not reported");
endmodule // dfc_top

// ===== hdl/dfc_pkg.sv
// Constants for the disk format command handler
// Function
// - Opcode 50h formats exactly one logical track; old data is lost.
// - Track format writes zeros to every good sector, no read-back verify.
// - A format table sent with track format is ignored; all sectors zeroed.
// - Every track is laid out identically at 1:1 interleave.
// - With L clear, cylinder from cylinder registers, head from head field.
// - With L set, 28-bit address from sector, cylinder low/high, head.
// - After block-address track format, current address reported back same mapping.
// - Block address beyond range ends track format with abort flag.
// - Block-address mode formats the whole track holding that address; the code stops at native maximum when the track runs past it.
// - Unit format merges reassignments into defects, clears them, zeroes sectors.
// - New reassign and defect data usable at completion; old data erased.
// - Unit format covers 0 to native maximum, ignoring all address limits.
// - Unit format without immediately preceding erase-prepare F3h is aborted.
// - Unit format has no data phase; data-request bit never set.
package dfc_pkg;
  localparam logic [7:0] OFF_SECT     = 8'h00;
  localparam logic [7:0] OFF_CYL_LO   = 8'h04;
  localparam logic [7:0] OFF_CYL_HI   = 8'h08;
  localparam logic [7:0] OFF_DRV_HEAD = 8'h0C;
  localparam logic [7:0] OFF_FEATURE  = 8'h10;
  localparam logic [7:0] OFF_COMMAND  = 8'h14;
  localparam logic [7:0] OFF_ERROR    = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  localparam logic [7:0] OFF_INT_STAT = 8'h20;
  localparam logic [7:0] OFF_INT_MASK = 8'h24;
  localparam logic [7:0] OFF_NAT_MAX  = 8'h28;
  localparam logic [7:0] OFF_REASSIGN = 8'h2C;
  localparam logic [7:0] OFF_DEFECT   = 8'h30;

  localparam logic [7:0] CMD_FMT_TRACK  = 8'h50;
  localparam logic [7:0] CMD_FMT_UNIT   = 8'hF7;
  localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
  localparam logic [7:0] FEAT_FMT_UNIT  = 8'h11;

  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;
  localparam int DH_LBA = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;

  localparam logic [7:0]  DH_RST      = 8'hA0;
  localparam logic [27:0] NAT_MAX_RST = 28'h0FFFFFF;
  localparam logic [27:0] SECT_PER_TRK = 28'h000003F;
  localparam logic [27:0] HEADS        = 28'h0000010;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ===== test/dfc_media_model.sv
// Media zero-write path model with selectable stalling
`timescale 1ns/1ps
module dfc_media_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        valid,
  input  wire logic [27:0] lba,
  input  wire logic        slow,
  input  wire logic        clr,
  output logic             ready,
  output int               count,
  output logic [27:0]      first,
  output logic [27:0]      last,
  output logic             in_order
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready    <= 1'b0;
      count    <= 0;
      first    <= 28'h0;
      last     <= 28'h0;
      in_order <= 1'b1;
    end else if (clr) begin
      count    <= 0;
      in_order <= 1'b1;
    end else begin
      // Slow mode stalls every other cycle
      ready <= slow ? ~ready : 1'b1;
      if (valid && ready) begin
        count <= count + 1;
        if (count == 0) begin
          first <= lba;
        end else if (lba !== last + 28'h1) begin
          in_order <= 1'b0;
        end
        last <= lba;
      end
    end
  end
endmodule // dfc_media_model

// ===== test/dfc_top_tb_top.sv
// Self-checking bench for the format command handler
`timescale 1ns/1ps
module dfc_top_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        slow = 1'b0;
  logic        clr = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mvalid, mready, irq, in_order;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd_val;
  logic [27:0] mlba, first, last;
  int          mcount;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  dfc_top dfc_top_inst (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MEDIA_ZERO_VALID(mvalid),
    .MEDIA_ZERO_LBA(mlba), .MEDIA_ZERO_READY(mready), .IRQ(irq));

  dfc_media_model dfc_media_model_inst (.clk(clk), .nrst(nrst), .valid(mvalid), .lba(mlba),
    .slow(slow), .clr(clr), .ready(mready), .count(mcount), .first(first), .last(last),
    .in_order(in_order));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Valids are dropped at the edge that samples ready high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    // Idle edge so a following call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, 2'h0);
    chk(nm, rd_val, e);
  endtask

  // Polls until busy drops; only the watchdog bounds the wait
  task automatic idle();
    do begin
      rd(dfc_pkg::OFF_STATUS, 2'h0);
      chk("drq", {31'h0, rd_val[3]}, 32'h0);
    end while (rd_val[7] !== 1'b0);
  endtask

  task automatic cmd(input logic [7:0] op);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(dfc_pkg::OFF_COMMAND, {24'h0, op}, 2'h0);
    idle();
  endtask

  task automatic media(input int n, input logic [27:0] f, input logic [27:0] l);
    chk("count", mcount, n);
    chk("first", {4'h0, first}, {4'h0, f});
    chk("last", {4'h0, last}, {4'h0, l});
    chk("order", {31'h0, in_order}, 32'h1);
  endtask

  task automatic t_reset();
    rdc("status", dfc_pkg::OFF_STATUS, 32'h50);
    rdc("dh", dfc_pkg::OFF_DRV_HEAD, 32'hA0);
    rdc("natmax", dfc_pkg::OFF_NAT_MAX, 32'h0FFFFFF);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h0);
    rd(8'h3C, dfc_pkg::RESP_SLVERR);
    wr(8'h3C, 32'h1, dfc_pkg::RESP_SLVERR);
  endtask

  // Cylinder 1 head 2 gives track start (16+2)*63
  task automatic t_chs();
    wr(dfc_pkg::OFF_NAT_MAX, 32'h7D0, 2'h0);
    wr(dfc_pkg::OFF_INT_MASK, 32'h3, 2'h0);
    wr(dfc_pkg::OFF_CYL_LO, 32'h1, 2'h0);
    wr(dfc_pkg::OFF_DRV_HEAD, 32'hA2, 2'h0);
    cmd(dfc_pkg::CMD_FMT_TRACK);
    media(63, 28'h46E, 28'h4AC);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h0);
    rdc("status", dfc_pkg::OFF_STATUS, 32'h50);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(dfc_pkg::OFF_INT_STAT, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  // Block address 1990 lies in the track starting at 1953, clipped at native max 2000
  task automatic t_lba();
    slow <= 1'b1;
    wr(dfc_pkg::OFF_SECT, 32'hC6, 2'h0);
    wr(dfc_pkg::OFF_CYL_LO, 32'h07, 2'h0);
    wr(dfc_pkg::OFF_DRV_HEAD, 32'hE0, 2'h0);
    cmd(dfc_pkg::CMD_FMT_TRACK);
    media(48, 28'h7A1, 28'h7D0);
    rdc("sect", dfc_pkg::OFF_SECT, 32'hD0);
    rdc("cyl_lo", dfc_pkg::OFF_CYL_LO, 32'h07);
    rdc("cyl_hi", dfc_pkg::OFF_CYL_HI, 32'h0);
    rd(dfc_pkg::OFF_DRV_HEAD, 2'h0);
    chk("head", {28'h0, rd_val[3:0]}, 32'h0);
    slow <= 1'b0;
    wr(dfc_pkg::OFF_INT_STAT, 32'h3, 2'h0);
  endtask

  task automatic t_range();
    wr(dfc_pkg::OFF_SECT, 32'hD1, 2'h0);
    cmd(dfc_pkg::CMD_FMT_TRACK);
    chk("count", mcount, 0);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h4);
    rdc("status", dfc_pkg::OFF_STATUS, 32'h51);
    rdc("intstat", dfc_pkg::OFF_INT_STAT, 32'h3);
    wr(dfc_pkg::OFF_INT_MASK, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(dfc_pkg::OFF_INT_STAT, 32'h3, 2'h0);
  endtask

  // Prepare only counts when it is the very last command
  task automatic t_unit();
    wr(dfc_pkg::OFF_REASSIGN, 32'h5, 2'h0);
    wr(dfc_pkg::OFF_FEATURE, 32'h11, 2'h0);
    cmd(dfc_pkg::CMD_FMT_UNIT);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h4);
    cmd(dfc_pkg::CMD_ERASE_PREP);
    cmd(dfc_pkg::CMD_FMT_TRACK);
    cmd(dfc_pkg::CMD_FMT_UNIT);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h4);
    chk("count", mcount, 0);
    // Reserved feature value is refused even when armed
    wr(dfc_pkg::OFF_FEATURE, 32'h12, 2'h0);
    cmd(dfc_pkg::CMD_ERASE_PREP);
    cmd(dfc_pkg::CMD_FMT_UNIT);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h4);
    chk("count", mcount, 0);
    cmd(8'h90);
    rdc("status", dfc_pkg::OFF_STATUS, 32'h51);
    rdc("reassign", dfc_pkg::OFF_REASSIGN, 32'h5);
    wr(dfc_pkg::OFF_FEATURE, 32'h11, 2'h0);
    cmd(dfc_pkg::CMD_ERASE_PREP);
    cmd(dfc_pkg::CMD_FMT_UNIT);
    rdc("error", dfc_pkg::OFF_ERROR, 32'h0);
    media(2001, 28'h0, 28'h7D0);
    rdc("reassign", dfc_pkg::OFF_REASSIGN, 32'h0);
    rdc("defect", dfc_pkg::OFF_DEFECT, 32'h5);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #900000;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_chs();
    t_lba();
    t_range();
    t_unit();
    summarize();
  end
endmodule // dfc_top_tb_top
